//--- status_word_pkg.sv
// Package of constants for the input/output module status word
package status_word_pkg;
  localparam logic [15:0] STATUS_WORD_ADDR = 16'h9C4E;
  localparam int          WORD_W           = 16;
  localparam int          CONTACT_N        = 6;
  localparam int          RELAY_N          = 2;
  localparam logic [15:0] STATUS_RESET     = 16'h0000;
  localparam logic [15:0] READ_UNMAPPED    = 16'h0000;
  // Bit positions inside the status word
  localparam int BIT_LOCATION    = 15;
  localparam int BIT_ACTIVATE_IN = 14;
  localparam int BIT_RETURN_IN   = 13;
  localparam int BIT_THERMAL_IN  = 12;
  localparam int BIT_FEEDBACK_IN = 11;
  localparam int BIT_SWITCHOFF   = 10;
  localparam int BIT_ALARM       = 8;
  localparam int BIT_RELAY_ONE   = 7;
  localparam int BIT_RELAY_TWO   = 6;

  typedef enum logic [1:0] {
    MODE_PLAIN_IO,
    MODE_MOTOR,
    MODE_MOTOR_VALVE,
    MODE_AIR_VALVE
  } op_mode_e;
endpackage

//--- in_sync.sv
// Two-flop synchroniser bank for the contact inputs
module in_sync #(
  parameter int W = 6
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rstn_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage_one_r;
  logic [W-1:0] stage_two_r;
  logic [W-1:0] stage_one_nxt;
  logic [W-1:0] stage_two_nxt;

  // Next values: hold while clock enable is low
  always_comb begin
    stage_one_nxt = ce_in ? async_in : stage_one_r;
    stage_two_nxt = ce_in ? stage_one_r : stage_two_r;
  end

  // First stage is read only by the second stage
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stage_one_r <= '0;
      stage_two_r <= '0;
    end else begin
      stage_one_r <= stage_one_nxt;
      stage_two_r <= stage_two_nxt;
    end
  end

  assign sync_out = stage_two_r;
endmodule

//--- io_module_status_word.sv
// Read-only status word of the digital input/output module
module io_module_status_word (
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  input  wire logic [1:0]  op_mode_in,
  input  wire logic        contact_in_one,
  input  wire logic        contact_in_two,
  input  wire logic        contact_in_three,
  input  wire logic        contact_in_four,
  input  wire logic        contact_in_five,
  input  wire logic        contact_in_six,
  input  wire logic        alarm_active_in,
  input  wire logic        relay_out_one,
  input  wire logic        relay_out_two,
  input  wire logic        rd_en_in,
  input  wire logic [15:0] rd_addr_in,
  output logic      [15:0] rd_data_out,
  output logic             rd_valid_out,
  output logic      [15:0] status_word_out
);
  localparam int CN = status_word_pkg::CONTACT_N;

  logic          rst_meta_r;
  logic          rst_sync_r;
  logic [CN-1:0] contacts_raw;
  logic [CN-1:0] contacts_s;
  logic [15:0]   status_r;
  logic [15:0]   status_nxt;
  logic [15:0]   rd_data_r;
  logic [15:0]   rd_data_nxt;
  logic          rd_valid_r;
  logic          rd_valid_nxt;
  status_word_pkg::op_mode_e mode;

  // Reset release through two flops
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Contact pins come from the field, so synchronise them
  assign contacts_raw = {contact_in_six, contact_in_five, contact_in_four,
                         contact_in_three, contact_in_two, contact_in_one};

  in_sync #(
    .W(CN)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rst_sync_r),
    .ce_in      (ce_in),
    .async_in   (contacts_raw),
    .sync_out   (contacts_s)
  );

  assign mode = status_word_pkg::op_mode_e'(op_mode_in);

  // Address decode for the data path only; valid follows rd_en_in alone
  function automatic logic hit(input logic [15:0] addr);
    hit = (addr == status_word_pkg::STATUS_WORD_ADDR);
  endfunction

  // Assemble the word; the contact wiring is the same in every mode,
  // only the meaning of each bit changes, so mode is decoded for clarity
  always_comb begin
    status_nxt = status_r;
    if (ce_in) begin
      status_nxt = status_word_pkg::STATUS_RESET;
      case (mode)
        status_word_pkg::MODE_PLAIN_IO: begin
          status_nxt[status_word_pkg::BIT_LOCATION] = contacts_s[0];
        end
        status_word_pkg::MODE_MOTOR,
        status_word_pkg::MODE_MOTOR_VALVE,
        status_word_pkg::MODE_AIR_VALVE: begin
          // Contact one serves as the local/remote selector here
          status_nxt[status_word_pkg::BIT_LOCATION] = contacts_s[0];
        end
        default: begin
          status_nxt[status_word_pkg::BIT_LOCATION] = contacts_s[0];
        end
      endcase
      status_nxt[status_word_pkg::BIT_ACTIVATE_IN] = contacts_s[1];
      status_nxt[status_word_pkg::BIT_RETURN_IN]   = contacts_s[2];
      status_nxt[status_word_pkg::BIT_THERMAL_IN]  = contacts_s[3];
      status_nxt[status_word_pkg::BIT_FEEDBACK_IN] = contacts_s[4];
      status_nxt[status_word_pkg::BIT_SWITCHOFF]   = contacts_s[5];
      status_nxt[status_word_pkg::BIT_ALARM]       = alarm_active_in;
      // Relays are driven on this clock, so no synchroniser needed
      status_nxt[status_word_pkg::BIT_RELAY_ONE]   = relay_out_one;
      status_nxt[status_word_pkg::BIT_RELAY_TWO]   = relay_out_two;
    end
  end

  // Read port: one cycle latency, unmapped addresses read zero
  always_comb begin
    rd_data_nxt  = rd_data_r;
    rd_valid_nxt = rd_valid_r;
    if (ce_in) begin
      rd_valid_nxt = rd_en_in;
      if (rd_en_in && hit(rd_addr_in)) begin
        rd_data_nxt = status_nxt;
      end else begin
        rd_data_nxt = status_word_pkg::READ_UNMAPPED;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk_sys_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      status_r   <= status_word_pkg::STATUS_RESET;
      rd_data_r  <= status_word_pkg::STATUS_RESET;
      rd_valid_r <= 1'b0;
    end else begin
      status_r   <= status_nxt;
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign rd_data_out     = rd_data_r;
  assign rd_valid_out    = rd_valid_r;
  assign status_word_out = status_r;
endmodule

//--- status_word_assertions.sv
// Checker for the status word block
module sw_chk (
  input wire logic        clk_sys_in,
  input wire logic        rstn_in,
  input wire logic        ce_in,
  input wire logic        contact_in_one,
  input wire logic        contact_in_two,
  input wire logic        alarm_active_in,
  input wire logic        relay_out_one,
  input wire logic        relay_out_two,
  input wire logic        rd_en_in,
  input wire logic [15:0] rd_addr_in,
  input wire logic [15:0] rd_data_out,
  input wire logic        rd_valid_out,
  input wire logic [15:0] status_word_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // Inputs stay low in reset, so lagged terms start clean
  chk_unused_zero: assert property (!status_word_out[9] && !status_word_out[5:0])
    else $error("unused set");
  chk_alarm_bit: assert property (ce_in |=> status_word_out[8] == $past(alarm_active_in))
    else $error("alarm bit");
  chk_relay_one: assert property (ce_in |=> status_word_out[7] == $past(relay_out_one))
    else $error("bit 7");
  chk_relay_two: assert property (ce_in |=> status_word_out[6] == $past(relay_out_two))
    else $error("bit 6");
  // Contacts pass two sync flops, then the word register
  chk_contact_one: assert property (ce_in [*3] |=> status_word_out[15] == $past(contact_in_one, 3))
    else $error("bit 15");
  chk_contact_two: assert property (ce_in [*3] |=> status_word_out[14] == $past(contact_in_two, 3))
    else $error("bit 14");
  chk_read_valid: assert property (rd_en_in && ce_in |=> rd_valid_out)
    else $error("no valid");
  chk_read_word: assert property (rd_en_in && ce_in && rd_addr_in == 16'h9C4E |=> rd_data_out == status_word_out)
    else $error("read data");
  cover property (rd_en_in && ce_in);
  cover property (rd_valid_out && rd_data_out[15]);
  cover property (alarm_active_in && relay_out_two);
endmodule
bind io_module_status_word sw_chk chk_u (.*);

//--- modbus_poller.sv
// Polling master model for status reads
module modbus_poller (
  input  wire logic        clk_sys_in,
  input  wire logic [15:0] rd_data_in,
  input  wire logic        rd_valid_in,
  output logic             rd_en_out,
  output logic      [15:0] rd_addr_out
);
  initial {rd_en_out, rd_addr_out} = 17'h00000;
  // One-cycle strobe; answer taken while valid stands
  task automatic poll(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk_sys_in);
    rd_en_out = 1'b1;
    rd_addr_out = a;
    @(negedge clk_sys_in);
    rd_en_out = 1'b0;
    d = rd_valid_in ? rd_data_in : 16'hDEAD;
  endtask
endmodule

//--- io_module_status_word_test.sv
// Bench for the status word block
module io_module_status_word_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rstn = 1'b0, al = 1'b0, r1 = 1'b0, r2 = 1'b0, en;
  logic [1:0]  mode = 2'h0;
  logic [5:0]  c = 6'h00;
  logic [15:0] a, q, w, d;
  logic        v;
  logic        ce = 1'b1;
  int          bad_count = 0, total_checks = 0;
  always #5 clk = ~clk;
  io_module_status_word dut_u (.clk_sys_in(clk), .rstn_in(rstn), .ce_in(ce), .op_mode_in(mode),
    .contact_in_one(c[5]), .contact_in_two(c[4]), .contact_in_three(c[3]),
    .contact_in_four(c[2]), .contact_in_five(c[1]), .contact_in_six(c[0]),
    .alarm_active_in(al), .relay_out_one(r1), .relay_out_two(r2), .rd_en_in(en),
    .rd_addr_in(a), .rd_data_out(q), .rd_valid_out(v), .status_word_out(w));
  modbus_poller m_u (.clk_sys_in(clk), .rd_data_in(q), .rd_valid_in(v), .rd_en_out(en),
    .rd_addr_out(a));
  task automatic chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One source at a time in every mode; last step all low
  task automatic t_map;
    for (int m = 0; m < 4; m++) begin
      for (int i = 0; i < 10; i++) begin
        mode = m[1:0];
        {c, al, r1, r2} = 9'h100 >> i;
        repeat (3) @(negedge clk);
        m_u.poll(16'h9C4E, d);
        chk(d, {c, 1'b0, al, r1, r2, 6'h00});
        chk(w, {c, 1'b0, al, r1, r2, 6'h00});
      end
    end
  endtask
  // Clock enable low: live word must hold although every source rises
  task automatic t_freeze;
    ce = 1'b0;
    {c, al, r1, r2} = 9'h1FF;
    repeat (4) @(negedge clk);
    chk(w, 16'h0000);
    ce = 1'b1;
    repeat (3) @(negedge clk);
    chk(w, 16'hFDC0);
  endtask
  // All high: stray address stays dark, unused bits stay low
  task automatic t_edge;
    {c, al, r1, r2} = 9'h1FF;
    repeat (3) @(negedge clk);
    m_u.poll(16'h9C4F, d);
    chk(d, 16'h0000);
    m_u.poll(16'h9C4E, d);
    chk(d, 16'hFDC0);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    t_map;
    t_freeze;
    t_edge;
    print_verdict;
  end
  // Tests need about 225 cycles
  initial begin
    #20000;
    bad_count++;
    print_verdict;
  end
endmodule
